// ==== bench/odgp_pins.sv ====
`timescale 1ns/1ns
module odgp_pins (
	input  wire logic [3:0] pin_oe,
	input  wire logic [3:0] drv,
	output logic      [3:0] pin
);
	// pull-down wins over the external source
	assign pin = drv & ~pin_oe;
endmodule

// ==== bench/odgp_props.sv ====
`timescale 1ns/1ns
module odgp_props (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] pin_in,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_irq
);
	logic [7:0] wd;
	logic [7:0] cf;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// only config writes, so an edge/mask write cannot disturb the oe check
	always_ff @(posedge clk)
		if (reg_wr && reg_addr == 8'h10) wd <= reg_wdata;
	always_ff @(posedge clk)
		if (sys_rst) cf <= 8'h00;
		else if (reg_wr && reg_addr == 8'h0F) cf <= reg_wdata;
	chk_out_low: assert property (pin_out == 4'h0)
		else $error("out");
	chk_rst_idle: assert property (disable iff (1'b0)
		sys_rst |=> pin_oe == 4'h0 && pin_irq == 4'h0) else $error("rst");
	chk_wr_oe: assert property (reg_wr && reg_addr == 8'h10
		|=> ##1 pin_oe == (wd[7:4] & wd[3:0])) else $error("oe");
	chk_unmap_rd: assert property (reg_rd && reg_addr == 8'h11
		|=> reg_rdata == 8'h00) else $error("unmap");
	chk_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("hold");
	chk_irq_in: assert property ((pin_irq & pin_oe) == 4'h0)
		else $error("irq out");
	chk_irq_mask: assert property ((pin_irq & cf[3:0]) == 4'h0)
		else $error("mask");
	chk_irq_edge: assert property ((pin_irq & (pin_in ^ cf[7:4])) == 0)
		else $error("edge");
	cover property (pin_irq != 4'h0);
	cover property (pin_oe != 4'h0);
	cover property (reg_rd && reg_addr == 8'h11);
endmodule
bind odgp_port odgp_props p_u (.*);

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [3:0] drv = 4'hF, pin, pin_out, pin_oe, pin_irq, acc;
	int err_total = 0, compares = 0;
	always #20 clk = ~clk;
	odgp_port dut_u (.*, .pin_in(pin));
	odgp_pins pm_u (.pin_oe(pin_oe), .drv(drv), .pin(pin));
	task ck(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk) reg_wr = 0;
	endtask
	task rd(input logic [7:0] a, e);
		@(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge clk) reg_rd = 0;
		ck(reg_rdata, e);
	endtask
	// gather irq pulses for a fixed span after the pins move
	task ev(input logic [3:0] d, input logic [7:0] e);
		@(negedge clk) drv = d;
		acc = 0;
		repeat (6) @(negedge clk) acc |= pin_irq;
		ck({4'h0, acc}, e);
	endtask
	task finish_test;
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#100000 err_total++;
		finish_test;
	end
	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 0;
		rd(8'h10, 8'h0F);
		ck({4'h0, pin_oe}, 8'h00);
		drv = 4'hB;
		wr(8'h10, 8'h35);
		rd(8'h10, 8'h39);
		ck({4'h0, pin_oe}, 8'h01);
		ck({4'h0, pin}, 8'h0A);
		ck({4'h0, pin_out}, 8'h00);
		rd(8'h11, 8'h00);
		wr(8'h0F, 8'h40);
		ev(4'hF, 8'h04);
		ev(4'h7, 8'h08);
		wr(8'h0F, 8'h44);
		rd(8'h0F, 8'h44);
		ev(4'h3, 8'h00);
		ev(4'h7, 8'h00);
		finish_test;
	end
endmodule

// ==== logic/odgp_port.sv ====
`timescale 1ns/1ns
module odgp_port
	import odgp_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// register access from the serial interface
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// pins
	input  wire logic [3:0] pin_in,
	output logic      [3:0] pin_out,
	output logic      [3:0] pin_oe,
	// pin events
	output logic      [3:0] pin_irq
);
	logic [3:0] dir;
	logic [3:0] level;
	logic [3:0] edge_sel;
	logic [3:0] mask;
	logic [3:0] pin_s;
	logic [3:0] pin_prev;
	logic [3:0] next_level;
	logic       wr_cfg;
	logic       wr_irq;

	for (genvar i = 0; i < ODGP_PINS; i++) begin : g_sync
		odgp_sync u_sync (
			.clk      (clk),
			.sys_rst  (sys_rst),
			.pin_in   (pin_in[i]),
			.pin_sync (pin_s[i])
		);
	end

	assign wr_cfg = reg_wr && (reg_addr == ODGP_ADDR_CONFIG);
	assign wr_irq = reg_wr && (reg_addr == ODGP_ADDR_IRQCTL);

	// a write that also turns a pin to output takes the written level;
	// the new direction decides, so a pin is never driven from stale data
	always_comb begin
		next_level = level;
		for (int i = 0; i < ODGP_PINS; i++) begin
			if (wr_cfg && reg_wdata[ODGP_DIR_LSB + i]) begin
				next_level[i] = reg_wdata[ODGP_LEVEL_LSB + i];
			end else if (!dir[i] && !(wr_cfg)) begin
				next_level[i] = pin_s[i];
			end else if (wr_cfg) begin
				next_level[i] = pin_s[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dir   <= ODGP_RST_CONFIG[ODGP_DIR_LSB +: 4];
			level <= ODGP_RST_CONFIG[ODGP_LEVEL_LSB +: 4];
		end else begin
			if (wr_cfg) begin
				dir <= reg_wdata[ODGP_DIR_LSB +: 4];
			end
			level <= next_level;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			edge_sel <= ODGP_RST_IRQCTL[ODGP_EDGE_LSB +: 4];
			mask     <= ODGP_RST_IRQCTL[ODGP_MASK_LSB +: 4];
		end else if (wr_irq) begin
			edge_sel <= reg_wdata[ODGP_EDGE_LSB +: 4];
			mask     <= reg_wdata[ODGP_MASK_LSB +: 4];
		end
	end

	// open drain: output data is always low, only the enable moves
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_out <= 4'h0;
			pin_oe  <= 4'h0;
		end else begin
			pin_out <= 4'h0;
			pin_oe  <= dir & level;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_prev <= 4'hF;
			pin_irq  <= 4'h0;
		end else begin
			pin_prev <= pin_s;
			for (int i = 0; i < ODGP_PINS; i++) begin
				pin_irq[i] <= !dir[i] && !mask[i] &&
					(edge_sel[i] ? (pin_s[i] && !pin_prev[i])
					             : (!pin_s[i] && pin_prev[i]));
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ODGP_ADDR_CONFIG: reg_rdata <= {dir, level};
				ODGP_ADDR_IRQCTL: reg_rdata <= {edge_sel, mask};
				default:          reg_rdata <= ODGP_READ_UNMAPPED;
			endcase
		end
	end
endmodule

// ==== logic/odgp_sync.sv ====
`timescale 1ns/1ns
module odgp_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// pin level
	input  wire logic pin_in,
	output logic      pin_sync
);
	logic stage1;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1   <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			stage1   <= pin_in;
			pin_sync <= stage1;
		end
	end
endmodule

// ==== pkg/odgp_pkg.sv ====
package odgp_pkg;
	localparam int         ODGP_PINS          = 4;
	localparam logic [7:0] ODGP_ADDR_CONFIG   = 8'h10;
	localparam logic [7:0] ODGP_ADDR_IRQCTL   = 8'h0F;
	localparam logic [7:0] ODGP_RST_CONFIG    = 8'h00;
	localparam logic [7:0] ODGP_RST_IRQCTL    = 8'h00;
	localparam int         ODGP_DIR_LSB       = 4;
	localparam int         ODGP_LEVEL_LSB     = 0;
	localparam int         ODGP_EDGE_LSB      = 4;
	localparam int         ODGP_MASK_LSB      = 0;
	localparam logic [7:0] ODGP_READ_UNMAPPED = 8'h00;
endpackage
